/* rtl/csf_pkg.sv */
// Purpose: shared constants and types for the clock source failover block
// Assumes: mclk at 250 MHz, 32-bit AHB-Lite register port
// Notes:   register offsets are byte addresses of aligned words
`default_nettype none

package csf_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_SEL = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  localparam logic [11:0] OFF_FLAG = 12'h00C;

  // bit 0 is fastOn, bit 7 is slowBypass
  typedef struct packed {
    logic slowBypass;
    logic slowOn;
    logic monitorEn;
    logic pllSrcExt;
    logic pllOn;
    logic fastIntOn;
    logic fastBypass;
    logic fastOn;
  } csf_ctrl_t;

  localparam csf_ctrl_t CTRL_RST = 8'h04;

  typedef enum logic [1:0] {
    SEL_INT = 2'h0,
    SEL_EXT = 2'h1,
    SEL_PLL = 2'h2
  } csf_sel_t;

  localparam int FLAG_FAIL_BIT = 0;
  localparam int STAT_FAST_RDY_BIT = 0;
  localparam int STAT_MON_BIT = 1;
  localparam int STAT_SLOW_RDY_BIT = 2;
  localparam int STAT_SEL_LSB = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int FAST_STARTUP_NS = 2000;
  localparam int FAIL_WINDOW_NS = 1000;
  localparam logic [9:0] FAST_STARTUP_CYC =
    10'((FAST_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] FAIL_WINDOW_CYC =
    10'((FAIL_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] SLOW_READY_EDGES = 3'h4;

endpackage

`default_nettype wire

/* rtl/csf_clock_failover.sv */
// Purpose: clock source control with fast external oscillator supervision
// Assumes: single clock mclk, synchronous active-low nrst, AHB-Lite slave
// Notes:   oscillator pins are sampled through two flip-flops before use
//
// How it works
// - fast external input works with a crystal or a bypass clock
// - fast bypass: outside drives about 50% duty, output pin left floating
// - slow bypass: up to 1 MHz clock in, slow output pin floating
// - slow external runs a 32.768 kHz crystal and may feed the RTC
// - failure monitor stays idle until software enables it
// - monitor starts after fast startup delay, stops when oscillator off
// - detected fast failure switches the fast oscillator off
// - failure is sent as an event to the timer break input
// - failure raises the clock failure interrupt on the NMI vector
// - system clock moves to internal oscillator if it used the failed one
// - PLL is switched off if it used the failed source for system clock
// - system clock chosen among internal, external and PLL
// - every clock source has its own on/off control
`default_nettype none

module csf_clock_failover (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // oscillator pins
  input wire logic fastOscInputPin,
  output logic fastOscOutputPin,
  output logic fastOscOutputPinOe,
  input wire logic slowOscInputPin,
  output logic slowOscOutputPin,
  output logic slowOscOutputPinOe,
  // clock tree controls
  output logic fastExtOscEn,
  output logic fastIntOscEn,
  output logic pllEn,
  output logic pllSrcFastExt,
  output logic [1:0] systemClockSel,
  output logic rtcClkFromSlowExt,
  // failure events
  output logic timerBreakPulse,
  output logic clockFailureIrq
);

  csf_pkg::csf_ctrl_t ctrl_q;
  csf_pkg::csf_sel_t sel_q;
  logic failFlag_q;
  logic brk_q;
  logic fastMeta_q, fastSync_q, fastDly_q;
  logic slowMeta_q, slowSync_q, slowDly_q;
  logic [9:0] startCnt_q;
  logic fastReady_q;
  logic [9:0] winCnt_q;
  logic [2:0] slowCnt_q;
  logic slowReady_q;
  logic wrPend_q;
  logic [11:0] wrAddr_q;
  logic [31:0] rdData_q;
  logic addrPhase, fastEdge, slowEdge, monActive, failDet, usesExt, pllOff;
  logic flagClr;
  logic [31:0] rdMux;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // zero wait states, so the data phase always completes in one cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdData_q;
  assign addrPhase = hsel && htrans[1] && hready;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 12'h000;
    end else begin
      wrPend_q <= addrPhase && hwrite && (hsize == 3'h2);
      wrAddr_q <= haddr;
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (haddr)
      csf_pkg::OFF_CTRL: rdMux[7:0] = ctrl_q;
      csf_pkg::OFF_SEL: rdMux[1:0] = sel_q;
      csf_pkg::OFF_STAT: begin
        rdMux[csf_pkg::STAT_FAST_RDY_BIT] = fastReady_q;
        rdMux[csf_pkg::STAT_MON_BIT] = monActive;
        rdMux[csf_pkg::STAT_SLOW_RDY_BIT] = slowReady_q;
        rdMux[csf_pkg::STAT_SEL_LSB +: 2] = sel_q;
      end
      csf_pkg::OFF_FLAG: rdMux[csf_pkg::FLAG_FAIL_BIT] = failFlag_q;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // read data captured at the address phase, stands through data phase
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdData_q <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      rdData_q <= rdMux;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fastMeta_q <= 1'b0;
      fastSync_q <= 1'b0;
      fastDly_q <= 1'b0;
      slowMeta_q <= 1'b0;
      slowSync_q <= 1'b0;
      slowDly_q <= 1'b0;
    end else begin
      fastMeta_q <= fastOscInputPin;
      fastSync_q <= fastMeta_q;
      fastDly_q <= fastSync_q;
      slowMeta_q <= slowOscInputPin;
      slowSync_q <= slowMeta_q;
      slowDly_q <= slowSync_q;
    end
  end

  // both edges count, so a running source restarts the window every half period
  assign fastEdge = fastSync_q ^ fastDly_q;
  assign slowEdge = slowSync_q ^ slowDly_q;

  // ----------------------------------------------------------------
  // startup and readiness
  // ----------------------------------------------------------------
  // startup delay gate
  always_ff @(posedge mclk) begin
    if (!nrst || !ctrl_q.fastOn) begin
      startCnt_q <= 10'h000;
      fastReady_q <= 1'b0;
    end else if (startCnt_q == csf_pkg::FAST_STARTUP_CYC - 10'h001) begin
      fastReady_q <= 1'b1;
    end else begin
      startCnt_q <= startCnt_q + 10'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst || !ctrl_q.slowOn) begin
      slowCnt_q <= 3'h0;
      slowReady_q <= 1'b0;
    end else if (slowCnt_q == csf_pkg::SLOW_READY_EDGES) begin
      slowReady_q <= 1'b1;
    end else if (slowEdge) begin
      slowCnt_q <= slowCnt_q + 3'h1;
    end
  end
  assign rtcClkFromSlowExt = slowReady_q;

  // ----------------------------------------------------------------
  // failure detector
  // ----------------------------------------------------------------
  // monitor active only when enabled, on and started
  assign monActive = ctrl_q.monitorEn && ctrl_q.fastOn && fastReady_q;

  always_ff @(posedge mclk) begin
    if (!nrst || !monActive || fastEdge) begin
      winCnt_q <= 10'h000;
    end else begin
      winCnt_q <= winCnt_q + 10'h001;
    end
  end
  assign failDet = monActive && !fastEdge &&
                   (winCnt_q == csf_pkg::FAIL_WINDOW_CYC - 10'h001);

  assign usesExt = (sel_q == csf_pkg::SEL_EXT) ||
                   ((sel_q == csf_pkg::SEL_PLL) && ctrl_q.pllSrcExt);
  assign pllOff = (sel_q == csf_pkg::SEL_PLL) && ctrl_q.pllSrcExt;
  assign flagClr = wrPend_q && (wrAddr_q == csf_pkg::OFF_FLAG) &&
                   hwdata[csf_pkg::FLAG_FAIL_BIT];

  // sticky flag, a new failure wins over the clear
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      failFlag_q <= 1'b0;
    end else if (failDet) begin
      failFlag_q <= 1'b1;
    end else if (flagClr) begin
      failFlag_q <= 1'b0;
    end
  end

  assign clockFailureIrq = failFlag_q;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      brk_q <= 1'b0;
    end else begin
      brk_q <= failDet;
    end
  end
  assign timerBreakPulse = brk_q;

  // ----------------------------------------------------------------
  // source control and system clock select
  // ----------------------------------------------------------------
  // per-source enables, failure overrides software
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl_q <= csf_pkg::CTRL_RST;
    end else begin
      if (wrPend_q && wrAddr_q == csf_pkg::OFF_CTRL) begin
        ctrl_q <= hwdata[7:0];
        // internal oscillator may not stop while it is the system clock
        if (sel_q == csf_pkg::SEL_INT) begin
          ctrl_q.fastIntOn <= 1'b1;
        end
      end
      if (failDet) begin
        ctrl_q.fastOn <= 1'b0;
        if (usesExt) begin
          ctrl_q.fastIntOn <= 1'b1;
        end
        // pll off with its failed reference only when it drives the system clock
        if (pllOff) begin
          ctrl_q.pllOn <= 1'b0;
        end
      end
    end
  end

  // software select, forced fallback on failure
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sel_q <= csf_pkg::SEL_INT;
    end else if (failDet && usesExt) begin
      sel_q <= csf_pkg::SEL_INT;
    end else if (wrPend_q && wrAddr_q == csf_pkg::OFF_SEL && hwdata[1:0] != 2'h3) begin
      sel_q <= csf_pkg::csf_sel_t'(hwdata[1:0]);
    end
  end

  assign fastExtOscEn = ctrl_q.fastOn;
  assign fastIntOscEn = ctrl_q.fastIntOn;
  assign pllEn = ctrl_q.pllOn;
  assign pllSrcFastExt = ctrl_q.pllSrcExt;
  assign systemClockSel = sel_q;

  // ----------------------------------------------------------------
  // oscillator output pins
  // ----------------------------------------------------------------
  // crystal mode drives the feedback pin, bypass leaves it floating
  assign fastOscOutputPinOe = ctrl_q.fastOn && !ctrl_q.fastBypass;
  assign fastOscOutputPin = !fastSync_q;
  // slow bypass keeps its output pin floating
  assign slowOscOutputPinOe = ctrl_q.slowOn && !ctrl_q.slowBypass;
  assign slowOscOutputPin = !slowSync_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  fail_stops_osc_a: assert property (failDet |=> !ctrl_q.fastOn)
    else $error("fast oscillator still on after failure");
  break_pulse_a: assert property (failDet |=> timerBreakPulse ##1 !timerBreakPulse)
    else $error("break event not a single pulse");
  // a clear written right after the failure may legally drop the flag
  irq_raised_a: assert property (failDet ##1 !flagClr |-> clockFailureIrq [*2])
    else $error("failure interrupt not raised");
  system_clock_fallback_a: assert property (failDet && usesExt |=> sel_q == csf_pkg::SEL_INT && fastIntOscEn)
    else $error("system clock not moved to internal oscillator");
  pll_stop_a: assert property (failDet && pllOff |=> !pllEn)
    else $error("pll left on after reference failure");
  monitor_gate_a: assert property (failDet |-> ctrl_q.monitorEn && $past(ctrl_q.monitorEn))
    else $error("failure detected with monitor disabled");
  startup_gate_a: assert property ($rose(fastReady_q) |-> $past(startCnt_q) == csf_pkg::FAST_STARTUP_CYC - 10'h001)
    else $error("monitor started before startup delay");
  fast_bypass_hiz_a: assert property (ctrl_q.fastBypass |-> !fastOscOutputPinOe)
    else $error("fast output pin driven in bypass");
  slow_bypass_hiz_a: assert property (ctrl_q.slowBypass |-> !slowOscOutputPinOe)
    else $error("slow output pin driven in bypass");
  fail_window_a: assert property (failDet |-> monActive && !fastEdge && $past(monActive))
    else $error("failure declared outside a monitored window");
  flag_sticky_a: assert property (failFlag_q && !flagClr |=> failFlag_q)
    else $error("failure flag dropped without a clear");

  fail_seen_c: cover property (failDet);
  fail_pll_c: cover property (failDet && pllOff);
  fail_keep_sel_c: cover property (failDet && !usesExt);
  flag_clear_c: cover property (failFlag_q ##1 flagClr ##1 !failFlag_q);

endmodule // csf_clock_failover

`default_nettype wire

/* verif/csf_osc_model.sv */
// Purpose: behavioural fast and slow oscillator sources at the device pins
// Assumes: the bench starts and stops each source on purpose
// Notes:   a stopped source holds its level, as a dead crystal would
`default_nettype none

module csf_osc_model (
  // bench commands
  input wire logic fastRun,
  input wire logic slowRun,
  // device pins
  output logic fastOscInputPin,
  output logic slowOscInputPin
);
  timeunit 1ns;
  timeprecision 100ps;

  // 8 MHz source, inside every variant's bypass limit and crystal range
  localparam real FAST_HALF_NS = 62.5;
  localparam int SLOW_HALF_NS = 500;

  initial fastOscInputPin = 1'b0;
  initial slowOscInputPin = 1'b0;

  always begin
    #(FAST_HALF_NS);
    if (fastRun) fastOscInputPin = ~fastOscInputPin;
  end

  always begin
    #(SLOW_HALF_NS);
    if (slowRun) slowOscInputPin = ~slowOscInputPin;
  end
endmodule // csf_osc_model

`default_nettype wire

/* verif/clock_source_failover_bench.sv */
// Purpose: self-checking bench for the clock source failover block
// Assumes: register port answers with no wait states
// Notes:   failures are provoked by stopping the fast source
`default_nettype none

module clock_source_failover_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, fastOscOutputPin, fastOscOutputPinOe;
  logic slowOscOutputPin, slowOscOutputPinOe, fastExtOscEn, fastIntOscEn;
  logic pllEn, pllSrcFastExt, rtcClkFromSlowExt, timerBreakPulse, clockFailureIrq;
  logic fastOscInputPin, slowOscInputPin;
  logic [1:0] systemClockSel;
  logic [31:0] hrdata, rd;
  logic fastRun = 1'b0;
  logic slowRun = 1'b1;
  int mismatches = 0;
  int total_checks = 0;

  always #2 mclk = ~mclk;

  csf_clock_failover dut (.mclk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .fastOscInputPin,
    .fastOscOutputPin, .fastOscOutputPinOe, .slowOscInputPin, .slowOscOutputPin,
    .slowOscOutputPinOe, .fastExtOscEn, .fastIntOscEn, .pllEn, .pllSrcFastExt,
    .systemClockSel, .rtcClkFromSlowExt, .timerBreakPulse, .clockFailureIrq);

  csf_osc_model osc (.fastRun, .slowRun, .fastOscInputPin, .slowOscInputPin);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // one single word transfer; ends just after its data phase
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask

  task automatic expect_reg(input string name, input logic [11:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(name, rd, exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    expect_reg("ctrl", csf_pkg::OFF_CTRL, 32'h4);
    expect_reg("sel", csf_pkg::OFF_SEL, 32'h0);
    expect_reg("flag", csf_pkg::OFF_FLAG, 32'h0);
    check("irq", clockFailureIrq, 32'h0);
    check("hresp", hresp, 32'h0);
    bus(12'h010, 1'b1, 32'hFF);
    expect_reg("unmapped", 12'h010, 32'h0);
    // internal oscillator stays on while it is the system clock
    bus(csf_pkg::OFF_CTRL, 1'b1, 32'h0);
    expect_reg("ctrl kept", csf_pkg::OFF_CTRL, 32'h4);
  endtask

  task automatic t_pins();
    bus(csf_pkg::OFF_CTRL, 1'b1, 32'h07);
    check("fast oe bypass", fastOscOutputPinOe, 32'h0);
    check("fast en", fastExtOscEn, 32'h1);
    bus(csf_pkg::OFF_CTRL, 1'b1, 32'h05);
    check("fast oe crystal", fastOscOutputPinOe, 32'h1);
    bus(csf_pkg::OFF_CTRL, 1'b1, 32'hC4);
    check("slow oe bypass", slowOscOutputPinOe, 32'h0);
    bus(csf_pkg::OFF_CTRL, 1'b1, 32'h44);
    check("slow oe crystal", slowOscOutputPinOe, 32'h1);
    tick(700);
    check("rtc source", rtcClkFromSlowExt, 32'h1);
    @(slowOscInputPin);
    tick(4);
    check("slow out pin", slowOscOutputPin, !slowOscInputPin);
    for (int s = 2; s >= 0; s--) begin
      bus(csf_pkg::OFF_SEL, 1'b1, 32'(s));
      check("sel", systemClockSel, 32'(s));
    end
    bus(csf_pkg::OFF_SEL, 1'b1, 32'h3);
    check("sel refused", systemClockSel, 32'h0);
  endtask

  // monitor left off: a dead source must go unnoticed
  task automatic t_idle();
    fastRun = 1'b0;
    bus(csf_pkg::OFF_CTRL, 1'b1, 32'h05);
    tick(800);
    check("irq idle", clockFailureIrq, 32'h0);
    check("fast kept", fastExtOscEn, 32'h1);
    check("fast out pin", fastOscOutputPin, 32'h1);
    bus(csf_pkg::OFF_STAT, 1'b0, 32'h0);
    check("monitor idle", rd[csf_pkg::STAT_MON_BIT], 32'h0);
    check("fast ready", rd[csf_pkg::STAT_FAST_RDY_BIT], 32'h1);
    check("slow ready off", rd[csf_pkg::STAT_SLOW_RDY_BIT], 32'h0);
    check("stat sel", rd[csf_pkg::STAT_SEL_LSB +: 2], 32'h0);
  endtask

  task automatic t_failover(input logic [31:0] ctrl, input logic [1:0] s, input logic pll);
    int n;
    fastRun = 1'b1;
    bus(csf_pkg::OFF_CTRL, 1'b1, 32'h04);
    bus(csf_pkg::OFF_SEL, 1'b1, 32'(s));
    bus(csf_pkg::OFF_CTRL, 1'b1, ctrl);
    check("pll src", pllSrcFastExt, 32'(ctrl[4]));
    bus(csf_pkg::OFF_STAT, 1'b0, 32'h0);
    check("monitor early", rd[csf_pkg::STAT_MON_BIT], 32'h0);
    tick(480);
    bus(csf_pkg::OFF_STAT, 1'b0, 32'h0);
    check("monitor before delay", rd[csf_pkg::STAT_MON_BIT], 32'h0);
    tick(120);
    bus(csf_pkg::OFF_STAT, 1'b0, 32'h0);
    check("monitor on", rd[csf_pkg::STAT_MON_BIT], 32'h1);
    fastRun = 1'b0;
    n = 0;
    while (timerBreakPulse !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    check("break", timerBreakPulse, 32'h1);
    // last source edge may precede the stop by up to half a source period
    check("window", 32'(n >= csf_pkg::FAIL_WINDOW_CYC - 10'h014 && n <= csf_pkg::FAIL_WINDOW_CYC + 10'h005), 32'h1);
    check("fast off", fastExtOscEn, 32'h0);
    check("irq", clockFailureIrq, 32'h1);
    check("sel back", systemClockSel, 32'h0);
    check("int on", fastIntOscEn, 32'h1);
    check("pll", pllEn, 32'(pll));
    tick(1);
    check("break end", timerBreakPulse, 32'h0);
    bus(csf_pkg::OFF_STAT, 1'b0, 32'h0);
    check("monitor stopped", rd[csf_pkg::STAT_MON_BIT], 32'h0);
    expect_reg("flag set", csf_pkg::OFF_FLAG, 32'h1);
    bus(csf_pkg::OFF_FLAG, 1'b1, 32'h1);
    expect_reg("flag clear", csf_pkg::OFF_FLAG, 32'h0);
    check("irq clear", clockFailureIrq, 32'h0);
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_pins();
    t_idle();
    t_failover(32'h39, 2'h2, 1'b0);
    t_failover(32'h29, 2'h1, 1'b1);
    t_failover(32'h3D, 2'h0, 1'b1);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    report_and_stop();
  end
endmodule // clock_source_failover_bench

`default_nettype wire
